// ### hdl/ctf_pkg.sv
// types shared by the tx framing block
// assumes nothing beyond the register header
package ctf_pkg;
  // transmit sequencer states
  typedef enum logic [2:0] {
    CTF_IDLE  = 3'b000,
    CTF_WAIT  = 3'b001,
    CTF_BURST = 3'b010,
    CTF_LEAD  = 3'b011,
    CTF_DATA  = 3'b100,
    CTF_PAR   = 3'b101,
    CTF_TRAIL = 3'b110,
    CTF_GUARD = 3'b111
  } ctf_state_t;
  // modulation scheme selection
  typedef enum logic [1:0] {
    CTF_MOD_MILLER_A = 2'b00,
    CTF_MOD_TYPE_B   = 2'b01,
    CTF_MOD_OTHER    = 2'b10
  } ctf_mod_t;
endpackage

// ### hdl/ctf_regs.svh
// register map, field positions, reset values and timing counts of the tx framing block
// assumes a 50 MHz system clock; included by the top module and the bench
`ifndef CTF_REGS_SVH
`define CTF_REGS_SVH
`define CTF_ADDR_PULSE_WIDTH   8'h2F
`define CTF_ADDR_BURST_LEN     8'h30
`define CTF_ADDR_WAIT_CTRL     8'h31
`define CTF_ADDR_WAIT_LOW      8'h32
`define CTF_ADDR_FRAME_CTRL    8'h33
`define CTF_ADDR_TX_CTRL       8'h40
`define CTF_ADDR_TX_DATA       8'h41
`define CTF_ADDR_STATUS        8'h42
`define CTF_ADDR_RX_DATA       8'h43
`define CTF_ADDR_RX_STATUS     8'h44
`define CTF_RST_WAIT_CTRL      8'hC0
`define CTF_RST_ZERO           8'h00
`define CTF_WC_ORIGIN_BIT      7
`define CTF_WC_UNIT_BIT        6
`define CTF_FC_TXPAR_BIT       7
`define CTF_FC_RXPAR_BIT       6
`define CTF_CARRIER_HZ         13560000
`define CTF_CLK_HZ             50000000
`define CTF_CARRIER_DIV        4
`define CTF_UNIT_CARRIERS      16
`define CTF_DEF_HALF_BIT       64
`endif

// ### hdl/ctf_top.sv
// contactless tx framing and timing block with a classic wishbone register slave
// assumes a 50 MHz clk_i, a carrier tick from the analog front end, and rx events
// from the receiver; one byte per write to the tx data register, bits sent lsb first
// Behaviour
// - pulse lasts programmed width plus one carriers
// - pulse truncated at end of its bit
// - width used only under type A Miller
// - same width for start and stop symbols
// - burst emitted with programmed length and level
// - burst codes map to 8..256 bits
// - wait origin: end of tx or rx
// - wait unit: 16 carriers or half bit
// - eleven bit wait count from two registers
// - wait is minimum gap before transmit
// - trailer guard code selects stop and egt
// - stop and egt only in type B
// - tx parity appended after each byte
// - rx parity checked, not passed on
// - trailer symbol code selects stop symbol
// - leader symbol code selects start symbol
// - wait control resets to C0
`timescale 1ns/1ns
`include "ctf_regs.svh"
module ctf_top
  import ctf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic       carrier_tick_i,
  input  wire logic [1:0] mod_scheme_i,
  input  wire logic       pulse_position_type_i,
  input  wire logic [7:0] half_bit_carriers_i,
  input  wire logic       rx_end_i,
  input  wire logic       rx_bit_valid_i,
  input  wire logic       rx_bit_i,
  output logic            tx_mod_o,
  output logic            tx_active_o
);

  // register file
  logic [7:0]  pulse_width_reg;   // pulse_carrier_count
  logic [7:0]  burst_len_reg;     // zero/one preamble lengths
  logic [7:0]  wait_ctrl_reg;     // origin, unit, high count, trailer guard
  logic [7:0]  wait_low_reg;      // guard_count_low
  logic [7:0]  frame_ctrl_reg;    // parity and symbol selects
  logic [2:0]  tx_ctrl_reg;       // preamble_level_ctrl, burst enable, burst symbol
  logic [7:0]  tx_data_reg;       // byte queued for sending
  logic        tx_pend_reg;       // byte waiting
  logic [7:0]  rx_data_reg;       // received byte, parity stripped
  logic        rx_perr_reg;       // sticky parity error
  logic        rx_full_reg;       // byte ready
  logic [31:0] dat_reg;
  logic        ack_reg;

  // sequencer and timing
  ctf_state_t  state_reg;
  logic [10:0] wait_cnt_reg;      // elapsed wait units
  logic [7:0]  unit_cnt_reg;      // carriers inside one unit
  logic [7:0]  car_cnt_reg;       // carriers inside current bit
  logic [8:0]  bit_cnt_reg;       // bits of current phase
  logic        mod_reg;
  logic        act_reg;
  logic [3:0]  rx_cnt_reg;
  logic [7:0]  rx_sh_reg;
  logic        rx_par_reg;

  // field views
  wire         origin_rx    = wait_ctrl_reg[`CTF_WC_ORIGIN_BIT];
  wire         unit_bit     = wait_ctrl_reg[`CTF_WC_UNIT_BIT];
  wire  [10:0] guard_count  = {wait_ctrl_reg[5:3], wait_low_reg};
  wire  [2:0]  b_trailer_guard_len = wait_ctrl_reg[2:0];
  wire         send_parity_on    = frame_ctrl_reg[`CTF_FC_TXPAR_BIT];
  wire         recv_parity_check = frame_ctrl_reg[`CTF_FC_RXPAR_BIT];
  wire  [1:0]  trailer_symbol_select = frame_ctrl_reg[3:2];
  wire  [1:0]  leader_symbol_select  = frame_ctrl_reg[1:0];
  wire         is_miller = (mod_scheme_i == CTF_MOD_MILLER_A);
  wire         is_type_b = (mod_scheme_i == CTF_MOD_TYPE_B);

  // wait unit length in carriers: 16 carriers or half a bit
  wire  [7:0]  unit_len = unit_bit ? half_bit_carriers_i : 8'h10;
  wire  [7:0]  bit_len  = {half_bit_carriers_i[6:0], 1'b0};
  wire         unit_end = carrier_tick_i && (unit_cnt_reg >= unit_len - 8'h01);
  wire         bit_end  = carrier_tick_i && (car_cnt_reg >= bit_len - 8'h01);
  wire         wait_done = (wait_cnt_reg >= guard_count);

  // burst length decode, codes 0..7 to 8..256 bits
  function automatic [8:0] burst_bits(input [2:0] code);
    case (code)
      3'h0: burst_bits = 9'd8;
      3'h1: burst_bits = 9'd16;
      3'h2: burst_bits = 9'd32;
      3'h3: burst_bits = 9'd48;
      3'h4: burst_bits = 9'd64;
      3'h5: burst_bits = 9'd96;
      3'h6: burst_bits = 9'd128;
      default: burst_bits = 9'd256;
    endcase
  endfunction
  wire  [8:0]  burst_target = tx_ctrl_reg[0] ? burst_bits(burst_len_reg[6:4])
                                             : burst_bits(burst_len_reg[2:0]);
  // trailer guard in bits: stop bit plus egt units, type B only
  wire  [8:0]  guard_bits = is_type_b ? {6'h00, b_trailer_guard_len} : 9'h000;

  // serial data bit and odd parity of queued byte
  wire         data_bit   = tx_data_reg[bit_cnt_reg[2:0]];
  wire         odd_par    = ~^tx_data_reg;
  // symbol code for leader and trailer: code0 no symbol, codes 1 and 3 modulate, code2 unmodulated
  wire  [1:0]  sym_code   = (state_reg == CTF_LEAD) ? leader_symbol_select
                                                    : trailer_symbol_select;
  // modulating level of current bit before pulse shaping
  wire         bit_level  = (state_reg == CTF_DATA) ? ~data_bit :
                            (state_reg == CTF_PAR)  ? ~odd_par  :
                            (state_reg == CTF_LEAD || state_reg == CTF_TRAIL) ?
                              (sym_code != 2'h2) : 1'b0;
  // pulse window: start at bit start or mid bit, end after width+1 carriers or bit end
  wire  [7:0]  pulse_start = pulse_position_type_i ? half_bit_carriers_i : 8'h00;
  wire  [8:0]  pulse_stop  = {1'b0, pulse_start} + {1'b0, pulse_width_reg} + 9'h001;
  wire         in_pulse    = (car_cnt_reg >= pulse_start) &&
                             ({1'b0, car_cnt_reg} < pulse_stop) &&
                             (car_cnt_reg < bit_len);
  wire         shaped      = is_miller ? (bit_level && in_pulse) : bit_level;
  wire         mod_next    = (state_reg == CTF_BURST) ? tx_ctrl_reg[2] :
                             (state_reg == CTF_GUARD) ? 1'b0 :
                             (state_reg == CTF_IDLE || state_reg == CTF_WAIT) ? 1'b0 :
                             shaped;

  // next sequencer state; past the wait it changes only at bit boundaries
  ctf_state_t  state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CTF_IDLE:  if (tx_pend_reg) state_next = CTF_WAIT;
      CTF_WAIT:  if (wait_done && carrier_tick_i) begin
                   if (tx_ctrl_reg[1]) state_next = CTF_BURST;
                   else if (leader_symbol_select != 2'h0) state_next = CTF_LEAD;
                   else state_next = CTF_DATA;
                 end
      CTF_BURST: if (bit_end && bit_cnt_reg == burst_target - 9'h001) begin
                   state_next = (leader_symbol_select != 2'h0) ? CTF_LEAD : CTF_DATA;
                 end
      CTF_LEAD:  if (bit_end) state_next = CTF_DATA;
      CTF_DATA:  if (bit_end && bit_cnt_reg == 9'h007) begin
                   if (send_parity_on) state_next = CTF_PAR;
                   else if (trailer_symbol_select != 2'h0) state_next = CTF_TRAIL;
                   else if (guard_bits != 9'h000) state_next = CTF_GUARD;
                   else state_next = CTF_IDLE;
                 end
      CTF_PAR:   if (bit_end) begin
                   if (trailer_symbol_select != 2'h0) state_next = CTF_TRAIL;
                   else if (guard_bits != 9'h000) state_next = CTF_GUARD;
                   else state_next = CTF_IDLE;
                 end
      CTF_TRAIL: if (bit_end) state_next = (guard_bits != 9'h000) ? CTF_GUARD : CTF_IDLE;
      CTF_GUARD: if (bit_end && bit_cnt_reg == guard_bits - 9'h001) state_next = CTF_IDLE;
      default:   state_next = CTF_IDLE;
    endcase
  end
  wire         phase_change = (state_next != state_reg);
  wire         tx_end       = phase_change && (state_next == CTF_IDLE);
  // leave the wait only on a carrier tick, else the first carrier of a pulse runs short
  wire         tx_start     = (state_reg == CTF_WAIT) && wait_done && carrier_tick_i;

  // wishbone decode
  wire         wb_req   = wb_cyc_i && wb_stb_i && !ack_reg;
  wire         wr_lane  = wb_req && wb_we_i && wb_sel_i[0];
  wire         wr_pw    = wr_lane && (wb_adr_i == `CTF_ADDR_PULSE_WIDTH);
  wire         wr_bl    = wr_lane && (wb_adr_i == `CTF_ADDR_BURST_LEN);
  wire         wr_wc    = wr_lane && (wb_adr_i == `CTF_ADDR_WAIT_CTRL);
  wire         wr_wl    = wr_lane && (wb_adr_i == `CTF_ADDR_WAIT_LOW);
  wire         wr_fc    = wr_lane && (wb_adr_i == `CTF_ADDR_FRAME_CTRL);
  wire         wr_tc    = wr_lane && (wb_adr_i == `CTF_ADDR_TX_CTRL);
  wire         wr_td    = wr_lane && (wb_adr_i == `CTF_ADDR_TX_DATA) && !tx_pend_reg;
  wire         rd_rx    = wb_req && !wb_we_i && (wb_adr_i == `CTF_ADDR_RX_DATA);
  wire         wr_rs    = wr_lane && (wb_adr_i == `CTF_ADDR_RX_STATUS);
  // read mux, unmapped reads as zero
  wire  [7:0]  rd_byte  =
    (wb_adr_i == `CTF_ADDR_PULSE_WIDTH) ? pulse_width_reg :
    (wb_adr_i == `CTF_ADDR_BURST_LEN)   ? {1'b0, burst_len_reg[6:4], 1'b0, burst_len_reg[2:0]} :
    (wb_adr_i == `CTF_ADDR_WAIT_CTRL)   ? wait_ctrl_reg :
    (wb_adr_i == `CTF_ADDR_WAIT_LOW)    ? wait_low_reg :
    (wb_adr_i == `CTF_ADDR_FRAME_CTRL)  ? {frame_ctrl_reg[7:6], 2'b00, frame_ctrl_reg[3:0]} :
    (wb_adr_i == `CTF_ADDR_TX_CTRL)     ? {5'h00, tx_ctrl_reg} :
    (wb_adr_i == `CTF_ADDR_TX_DATA)     ? tx_data_reg :
    (wb_adr_i == `CTF_ADDR_STATUS)      ? {1'b0, state_reg, 2'b00, act_reg, tx_pend_reg} :
    (wb_adr_i == `CTF_ADDR_RX_DATA)     ? rx_data_reg :
    (wb_adr_i == `CTF_ADDR_RX_STATUS)   ? {6'h00, rx_perr_reg, rx_full_reg} :
    8'h00;

  // bus slave: one wait state then ack
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= wb_req;
      dat_reg <= {24'h000000, rd_byte};
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_width_reg <= `CTF_RST_ZERO;
      burst_len_reg   <= `CTF_RST_ZERO;
      wait_ctrl_reg   <= `CTF_RST_WAIT_CTRL;
      wait_low_reg    <= `CTF_RST_ZERO;
      frame_ctrl_reg  <= `CTF_RST_ZERO;
      tx_ctrl_reg     <= 3'h0;
    end else begin
      if (wr_pw) pulse_width_reg <= wb_dat_i[7:0];
      if (wr_bl) burst_len_reg   <= wb_dat_i[7:0] & 8'h77;
      if (wr_wc) wait_ctrl_reg   <= wb_dat_i[7:0];
      if (wr_wl) wait_low_reg    <= wb_dat_i[7:0];
      if (wr_fc) frame_ctrl_reg  <= wb_dat_i[7:0] & 8'hCF;
      if (wr_tc) tx_ctrl_reg     <= wb_dat_i[2:0];
    end
  end

  // tx byte hand-off; a write while pending is dropped
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_data_reg <= 8'h00;
      tx_pend_reg <= 1'b0;
    end else begin
      if (wr_td) tx_data_reg <= wb_dat_i[7:0];
      if (wr_td) tx_pend_reg <= 1'b1;
      else if (tx_end) tx_pend_reg <= 1'b0;
    end
  end

  // wait counter restarts at the selected origin event
  wire         origin_evt = origin_rx ? rx_end_i : tx_end;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_cnt_reg <= 11'h7FF;
      unit_cnt_reg <= 8'h00;
    end else if (origin_evt) begin
      wait_cnt_reg <= 11'h000;
      unit_cnt_reg <= 8'h00;
    end else if (unit_end) begin
      unit_cnt_reg <= 8'h00;
      if (wait_cnt_reg != 11'h7FF) wait_cnt_reg <= wait_cnt_reg + 11'h001;
    end else if (carrier_tick_i) begin
      unit_cnt_reg <= unit_cnt_reg + 8'h01;
    end
  end

  // bit timing and sequencer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg   <= CTF_IDLE;
      car_cnt_reg <= 8'h00;
      bit_cnt_reg <= 9'h000;
      mod_reg     <= 1'b0;
      act_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      mod_reg   <= mod_next;
      act_reg   <= (state_reg != CTF_IDLE) && (state_reg != CTF_WAIT);
      if (tx_start || phase_change) begin
        car_cnt_reg <= 8'h00;
        bit_cnt_reg <= 9'h000;
      end else if (bit_end) begin
        car_cnt_reg <= 8'h00;
        bit_cnt_reg <= bit_cnt_reg + 9'h001;
      end else if (carrier_tick_i) begin
        car_cnt_reg <= car_cnt_reg + 8'h01;
      end
    end
  end

  // receive parity strip and check: ninth bit is parity when enabled
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_cnt_reg  <= 4'h0;
      rx_sh_reg   <= 8'h00;
      rx_par_reg  <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
    end else begin
      if (rd_rx) rx_full_reg <= 1'b0;
      if (wr_rs && wb_dat_i[1]) rx_perr_reg <= 1'b0;
      if (rx_end_i) rx_cnt_reg <= 4'h0;
      else if (rx_bit_valid_i) begin
        if (rx_cnt_reg < 4'h8) begin
          rx_sh_reg  <= {rx_bit_i, rx_sh_reg[7:1]};
          rx_par_reg <= rx_par_reg ^ rx_bit_i;
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == 4'h7 && !recv_parity_check) begin
            rx_data_reg <= {rx_bit_i, rx_sh_reg[7:1]};
            rx_full_reg <= 1'b1;
            rx_cnt_reg  <= 4'h0;
            rx_par_reg  <= 1'b0;
          end
        end else begin
          rx_data_reg <= rx_sh_reg;
          rx_full_reg <= 1'b1;
          if (!(rx_par_reg ^ rx_bit_i)) rx_perr_reg <= 1'b1;
          rx_cnt_reg  <= 4'h0;
          rx_par_reg  <= 1'b0;
        end
      end
    end
  end

  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = dat_reg;
  assign tx_mod_o    = mod_reg;
  assign tx_active_o = act_reg;

endmodule // ctf_top

// ### verif/ctf_card_model.sv
// card side model: carrier ticks, frame measurement and answering byte frames
// assumes a 50 MHz clock, so one carrier period is four clocks here
`timescale 1ns/1ns
module ctf_card_model (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        tx_mod_i,
  input  wire logic        tx_active_i,
  input  wire logic        rsp_go_i,
  input  wire logic [7:0]  rsp_byte_i,
  input  wire logic        rsp_bad_i,
  output logic             carrier_tick_o,
  output logic             rx_end_o,
  output logic             rx_bit_valid_o,
  output logic             rx_bit_o,
  output logic             frame_done_o,
  output logic [15:0]      act_clks_o,
  output logic [15:0]      mod_clks_o
);
  logic [1:0] div_reg;   // carrier divider
  logic       act_reg;   // tx_active one clock late
  logic [3:0] left_reg;  // answer slots still to send
  logic [8:0] sh_reg;    // answer bits, lsb first, parity last
  // counts stay until the next frame starts so the bench reads them at leisure
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {div_reg, act_reg, left_reg, sh_reg, carrier_tick_o, rx_end_o} <= '0;
      {rx_bit_valid_o, rx_bit_o, frame_done_o, act_clks_o, mod_clks_o} <= '0;
    end else begin
      div_reg <= div_reg + 2'h1;
      carrier_tick_o <= (div_reg == 2'h3);
      act_reg <= tx_active_i;
      frame_done_o <= act_reg && !tx_active_i;
      if (!act_reg && tx_active_i) {act_clks_o, mod_clks_o} <= {16'h0001, 15'h0000, tx_mod_i};
      else begin
        if (tx_active_i) act_clks_o <= act_clks_o + 16'h0001;
        if (tx_mod_i) mod_clks_o <= mod_clks_o + 16'h0001;
      end
      rx_bit_valid_o <= 1'b0;
      rx_end_o <= 1'b0;
      rx_bit_o <= ~rx_bit_o; // idle data line never holds the last bit
      if (rsp_go_i) begin
        sh_reg <= {rsp_bad_i ^ ~^rsp_byte_i, rsp_byte_i};
        left_reg <= 4'hA;
      end else if (div_reg == 2'h0 && left_reg != 4'h0) begin
        left_reg <= left_reg - 4'h1;
        if (left_reg == 4'h1) rx_end_o <= 1'b1;
        else begin
          rx_bit_valid_o <= 1'b1;
          rx_bit_o <= sh_reg[0];
          sh_reg <= sh_reg >> 1;
        end
      end
    end
  end
endmodule // ctf_card_model

// ### verif/ctf_chk.sv
// assertions on the register port and transmit timing of the tx framing block
// assumes it is bound to ctf_top and sees only that module's ports
`timescale 1ns/1ns
module ctf_chk (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        carrier_tick_i,
  input  wire logic        rx_end_i,
  input  wire logic        tx_mod_o,
  input  wire logic        tx_active_o
);
  logic [7:0]  mirror_reg [5];        // last value written per framing register
  logic [7:0]  radr_reg;              // address of the last request taken
  logic [7:0]  roff, woff, rmask;     // offsets; reserved bits are not compared
  logic        take, rd_reg, pend_reg, act_reg;
  logic [15:0] ticks_reg;             // carriers since the wait origin, saturating
  assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign roff  = radr_reg - 8'h2F;
  assign woff  = wb_adr_i - 8'h2F;
  assign rmask = (radr_reg == 8'h30) ? 8'h77 : ((radr_reg == 8'h33) ? 8'hCF : 8'hFF);
  // mirror writes; the origin follows the bit in force, so a change mid-wait is seen
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mirror_reg <= '{8'h00, 8'h00, 8'hC0, 8'h00, 8'h00};
      {radr_reg, rd_reg, pend_reg, act_reg} <= '0;
      ticks_reg <= 16'hFFFF;
    end else begin
      rd_reg <= take && !wb_we_i;
      if (take) radr_reg <= wb_adr_i;
      if (take && wb_we_i && wb_sel_i[0] && (wb_adr_i inside {[8'h2F:8'h33]}))
        mirror_reg[woff[2:0]] <= wb_dat_i[7:0];
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h41) pend_reg <= 1'b1;
      else if (act_reg && !tx_active_o) pend_reg <= 1'b0;
      act_reg <= tx_active_o;
      if ((act_reg && !tx_active_o && !mirror_reg[2][7]) || (rx_end_i && mirror_reg[2][7]))
        ticks_reg <= 16'h0000;
      else if (carrier_tick_i && ticks_reg != 16'hFFFF) ticks_reg <= ticks_reg + 16'h0001;
    end
  end
  chk_ack_timing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack is not one pulse after a request");
  chk_ack_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wb_ack_o |-> $past(take)) else $error("ack without a request");
  chk_read_upper: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper read bits not zero");
  chk_reg_readback: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_reg && wb_ack_o && (radr_reg inside {[8'h2F:8'h33]}) |->
    ((wb_dat_o[7:0] ^ mirror_reg[roff[2:0]]) & rmask) == 8'h00) else $error("readback wrong");
  chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_reg && wb_ack_o && !(radr_reg inside {[8'h2F:8'h33], [8'h40:8'h44]}) |->
    wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
  chk_tx_needs_byte: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(tx_active_o) |-> pend_reg) else $error("transmit without a byte");
  chk_wait_gap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(tx_active_o) && !mirror_reg[2][6] |-> ticks_reg + 16'h0010 >=
    {1'b0, mirror_reg[2][5:3], mirror_reg[3], 4'h0}) else $error("send wait too short");
  chk_mod_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !tx_active_o && !$past(tx_active_o) |-> !tx_mod_o) else $error("modulation while idle");
endmodule // ctf_chk
bind ctf_top ctf_chk chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .carrier_tick_i(carrier_tick_i),
  .rx_end_i(rx_end_i), .tx_mod_o(tx_mod_o), .tx_active_o(tx_active_o));

// ### verif/tb_contactless_tx_frame_timing.sv
// bench for the tx framing block: registers, frame shape, wait gap, rx parity
// assumes the card model gives carrier ticks; half bit is 8 carriers, 64 clocks a bit
`timescale 1ns/1ns
`include "ctf_regs.svh"
module tb_contactless_tx_frame_timing import ctf_pkg::*;;
  typedef struct {string nm; logic [15:0] v;} ctf_note_t;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, pos = 1'b0, rsp_go = 1'b0, rsp_bad = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, half = 8'h08, rsp_byte = 8'h00, wc_top = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rnd = 32'hB754;
  logic [1:0]  mode = CTF_MOD_MILLER_A;
  logic        wb_ack_o, tick, rx_end, rx_bv, rx_bit, tx_mod, tx_act, done;
  logic [15:0] act_clks, mod_clks;
  int          failures = 0, comparisons = 0, blen[8] = '{8, 16, 32, 48, 64, 96, 128, 256};
  ctf_note_t   exp_q[$];  // expected results in the order they appear
  ctf_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .carrier_tick_i(tick),
    .mod_scheme_i(mode), .pulse_position_type_i(pos), .half_bit_carriers_i(half),
    .rx_end_i(rx_end), .rx_bit_valid_i(rx_bv), .rx_bit_i(rx_bit), .tx_mod_o(tx_mod),
    .tx_active_o(tx_act));
  ctf_card_model card_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_mod_i(tx_mod),
    .tx_active_i(tx_act), .rsp_go_i(rsp_go), .rsp_byte_i(rsp_byte), .rsp_bad_i(rsp_bad),
    .carrier_tick_o(tick), .rx_end_o(rx_end), .rx_bit_valid_o(rx_bv), .rx_bit_o(rx_bit),
    .frame_done_o(done), .act_clks_o(act_clks), .mod_clks_o(mod_clks));
  initial forever #10 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic note(input string nm, input logic [15:0] v);
    exp_q.push_back('{nm, v});
  endtask
  // every wait is bounded; running out ends the run as a mismatch
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin failures++; report_and_stop; end
  endtask
  // one classic cycle, held until ack is sampled, then one idle cycle
  task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, a, 4'h1};
    wb_dat_i <= {24'h000000, d};
    wait_hi(wb_ack_o, 50);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  // takes the oldest note whenever a read answer or a finished frame shows up
  task automatic take_note(input logic [15:0] seen);
    ctf_note_t n;
    if (exp_q.size() == 0) begin failures++; $display("BAD surplus seen %h", seen); end
    else begin
      n = exp_q.pop_front();
      if (n.v !== 16'hFFFF) check(n.nm, seen, n.v);
    end
  endtask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) take_note(wb_dat_o[15:0]);
    if (done === 1'b1) begin
      take_note((act_clks + 16'h0020) / 16'h0040);
      take_note((mod_clks + 16'h0002) / 16'h0004);
    end
  end
  // bu: [3] burst on, [2:0] length code, code lsb picks the symbol; burst level low
  task automatic frame(input logic [7:0] b, w, input logic [1:0] m, input logic p, par,
                       input logic [1:0] ld, tr, input logic [2:0] gd, input logic [3:0] bu);
    int pw, bits, carr;
    pw = (m != CTF_MOD_MILLER_A) ? 16 : ((w + 1 < (p ? 8 : 16)) ? w + 1 : (p ? 8 : 16));
    carr = pw * (8 - $countones(b) + (par && ^b) + (ld inside {1, 3}) + (tr inside {1, 3}));
    bits = 8 + par + (ld != 0) + (tr != 0) + (m == CTF_MOD_TYPE_B ? gd : 0);
    bits += bu[3] ? blen[bu[2:0]] : 0;
    wb(8'h2F, 1'b1, w);
    wb(8'h30, 1'b1, {1'b0, bu[2:0], 1'b0, bu[2:0]});
    wb(8'h31, 1'b1, wc_top | {5'h00, gd});
    wb(8'h33, 1'b1, {par, par, 2'b00, tr, ld});
    wb(8'h40, 1'b1, {6'h00, bu[3], bu[0]});
    {mode, pos} <= {m, p};
    note("frame_bits", bits[15:0]);
    note("mod_carriers", carr[15:0]);
    wb(8'h41, 1'b1, b);
    wait_hi(done, 20000);
  endtask
  task automatic rx_frame(input logic bad);
    rnd = xs(rnd);
    {rsp_byte, rsp_bad, rsp_go} <= {rnd[7:0], bad, 1'b1};
    @(posedge clk_i);
    rsp_go <= 1'b0;
    wait_hi(rx_end, 200);
    @(posedge clk_i);
    note("rx_status", {14'h0000, bad, 1'b1});
    wb(8'h44, 1'b0, 8'h00);
    note("rx_data", {8'h00, rnd[7:0]});
    wb(8'h43, 1'b0, 8'h00);
    wb(8'h44, 1'b1, 8'h02);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    note("wait_ctrl", 16'h00C0);
    wb(8'h31, 1'b0, 8'h00);
    note("unmapped", 16'h0000);
    wb(8'h50, 1'b0, 8'h00);
    for (int k = 0; k < 5; k++) begin
      rnd = xs(rnd);
      wb(8'h2F + k[7:0], 1'b1, rnd[7:0]);
      note("readback", {8'h00, rnd[7:0] & (k == 1 ? 8'h77 : (k == 4 ? 8'hCF : 8'hFF))});
      wb(8'h2F + k[7:0], 1'b0, 8'h00);
    end
    wb(8'h32, 1'b1, 8'h00);
    frame(8'hFE, 8'd9, CTF_MOD_MILLER_A, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0, 4'h0);
    frame(8'hFE, 8'hFF, CTF_MOD_MILLER_A, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0, 4'h0);
    frame(8'hFE, 8'hFF, CTF_MOD_MILLER_A, 1'b1, 1'b0, 2'h0, 2'h0, 3'h0, 4'h0);
    frame(8'hFE, 8'd3, CTF_MOD_OTHER, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0, 4'h0);
    frame(8'h5A, 8'd3, CTF_MOD_MILLER_A, 1'b0, 1'b0, 2'h0, 2'h0, 3'h7, 4'h0);
    for (int k = 0; k < 8; k++) begin
      rnd = xs(rnd);
      frame(rnd[7:0], 8'd3, CTF_MOD_MILLER_A, 1'b0, 1'b1, k[1:0], ~k[1:0], 3'h0, 4'h0);
      frame(8'hFF, 8'd3, CTF_MOD_TYPE_B, 1'b0, 1'b0, 2'h0, 2'h0, k[2:0], 4'h0);
      frame(8'hFF, 8'd3, CTF_MOD_MILLER_A, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0, {1'b1, k[2:0]});
    end
    wb(8'h33, 1'b1, 8'hC0);
    rx_frame(1'b0);
    rx_frame(1'b1);
    wb(8'h32, 1'b1, 8'h0A);
    for (int k = 0; k < 4; k++) begin
      wc_top = {k[1], k == 0, 6'h00};
      if (k[1]) rx_frame(1'b0);
      frame(8'hA5, 8'd3, CTF_MOD_MILLER_A, 1'b0, 1'b1, 2'h0, 2'h0, 3'h0, 4'h0);
    end
    repeat (2) @(posedge clk_i);
    check("notes_left", exp_q.size(), 16'h0000);
    report_and_stop;
  end
endmodule // tb_contactless_tx_frame_timing
